// [pkg/cpu_flags_pkg.sv]
package cpu_flags_pkg;

	// ------------------------------------------------------------
	// Flag positions inside condition_flags
	// ------------------------------------------------------------
	localparam int FLAG_WIDTH  = 8;
	localparam int HALF_BIT    = 5;
	localparam int USER_BIT    = 4;
	localparam int NEG_BIT     = 3;
	localparam int ZERO_BIT    = 2;
	localparam int OVF_BIT     = 1;
	localparam int CARRY_BIT   = 0;

	// ------------------------------------------------------------
	// Half-carry positions per operand size
	// ------------------------------------------------------------
	localparam int HALF_POS_BYTE = 3;
	localparam int HALF_POS_WORD = 11;
	localparam int HALF_POS_LONG = 27;

	// ------------------------------------------------------------
	// Update masks, one bit per flag that an operation writes
	// ------------------------------------------------------------
	localparam logic [7:0] MASK_ARITH = 8'h2f;
	localparam logic [7:0] MASK_LOGIC = 8'h0e;
	localparam logic [7:0] MASK_SHIFT = 8'h0f;
	localparam logic [7:0] MASK_BIT   = 8'h01;
	localparam logic [7:0] MASK_FLAGS = 8'h3f;
	localparam logic [7:0] MASK_NONE  = 8'h00;

	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_WORD,
		SIZE_LONG
	} size_t;

	typedef enum logic [4:0] {
		K_NOP,
		K_ADD,
		K_ADDX,
		K_SUB,
		K_SUBX,
		K_CMP,
		K_NEG,
		K_LOGIC,
		K_SHIFT,
		K_BLOAD,
		K_BAND,
		K_BOR,
		K_BXOR,
		K_LOAD_FLAGS,
		K_AND_FLAGS,
		K_OR_FLAGS,
		K_XOR_FLAGS
	} kind_t;

endpackage

// [src/cpu_condition_flags.sv]
`timescale 1ns/1ps

// Operation
// - byte arithmetic half-carry from bit 3
// - word arithmetic half-carry from bit 11
// - longword arithmetic half-carry from bit 27
// - bit 4 user bit, flag instructions only
// - negative flag takes result sign bit
// - zero flag set on all-zero result, except extended forms, which only clear it
// - overflow flag marks signed overflow
// - carry flag marks addition carry out
// - carry flag marks subtraction borrow
// - carry takes shifted or rotated-out bit
// - carry serves as bit-operation accumulator
// - flags are not initialised by reset
module cpu_condition_flags
	import cpu_flags_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Operation from the execution datapath
	input  wire logic        op_valid,
	input  wire kind_t       op_kind,
	input  wire size_t       op_size,
	input  wire logic [31:0] operand_a,
	input  wire logic [31:0] operand_b,
	input  wire logic        shift_out,
	input  wire logic        bit_value,
	input  wire logic        bit_invert,
	// Flag register and datapath result
	output logic      [7:0]  condition_flags,
	output logic      [31:0] op_result
);

	// ------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------
	logic [31:0] add_a;
	logic [31:0] add_b;
	logic        add_cin;
	logic        add_sub;
	logic [31:0] add_sum;
	logic        add_half;
	logic        add_carry;
	logic        add_ovf;

	always_comb begin
		add_a   = operand_a;
		add_b   = operand_b;
		add_cin = 1'b0;
		add_sub = 1'b0;
		unique case (op_kind)
			K_ADDX: add_cin = condition_flags[CARRY_BIT];
			K_SUB, K_CMP: add_sub = 1'b1;
			K_SUBX: begin
				add_sub = 1'b1;
				add_cin = condition_flags[CARRY_BIT];
			end
			K_NEG: begin
				add_a   = 32'h0;
				add_sub = 1'b1;
			end
			default: add_sub = 1'b0;
		endcase
	end

	flag_adder u_adder (
		.a        (add_a),
		.b        (add_b),
		.carry_in (add_cin),
		.subtract (add_sub),
		.size     (op_size),
		.sum      (add_sum),
		.half     (add_half),
		.carry    (add_carry),
		.ovf      (add_ovf)
	);

	// ------------------------------------------------------------
	// Result, sign and zero for the operand size
	// ------------------------------------------------------------
	logic [31:0] next_result;
	logic [31:0] sized;
	logic        res_neg;
	logic        res_zero;

	always_comb begin
		unique case (op_kind)
			K_ADD, K_ADDX, K_SUB, K_SUBX, K_CMP, K_NEG: next_result = add_sum;
			default: next_result = operand_a;
		endcase
	end

	always_comb begin
		unique case (op_size)
			SIZE_BYTE: begin
				sized   = {24'h0, next_result[7:0]};
				res_neg = next_result[7];
			end
			SIZE_WORD: begin
				sized   = {16'h0, next_result[15:0]};
				res_neg = next_result[15];
			end
			default: begin
				sized   = next_result;
				res_neg = next_result[31];
			end
		endcase
	end

	assign res_zero = (sized == 32'h0);

	// ------------------------------------------------------------
	// Next flag values and update mask
	// ------------------------------------------------------------
	logic [7:0] next_flags;
	logic [7:0] update_mask;
	logic       bit_in;

	assign bit_in = bit_value ^ bit_invert;

	always_comb begin
		next_flags  = condition_flags;
		update_mask = MASK_NONE;
		unique case (op_kind)
			K_ADD, K_ADDX, K_SUB, K_SUBX, K_CMP, K_NEG: begin
				update_mask           = MASK_ARITH;
				next_flags[HALF_BIT]  = add_half;
				next_flags[NEG_BIT]   = res_neg;
				next_flags[OVF_BIT]   = add_ovf;
				next_flags[CARRY_BIT] = add_carry;
				// Extended forms only clear zero so multi-word chains test the whole value.
				if (op_kind == K_ADDX || op_kind == K_SUBX) begin
					next_flags[ZERO_BIT] = res_zero & condition_flags[ZERO_BIT];
				end else begin
					next_flags[ZERO_BIT] = res_zero;
				end
			end
			K_LOGIC: begin
				update_mask          = MASK_LOGIC;
				next_flags[NEG_BIT]  = res_neg;
				next_flags[ZERO_BIT] = res_zero;
				next_flags[OVF_BIT]  = 1'b0;
			end
			K_SHIFT: begin
				update_mask           = MASK_SHIFT;
				next_flags[NEG_BIT]   = res_neg;
				next_flags[ZERO_BIT]  = res_zero;
				next_flags[OVF_BIT]   = 1'b0;
				next_flags[CARRY_BIT] = shift_out;
			end
			K_BLOAD, K_BAND, K_BOR, K_BXOR: begin
				update_mask = MASK_BIT;
				unique case (op_kind)
					K_BLOAD: next_flags[CARRY_BIT] = bit_in;
					K_BAND:  next_flags[CARRY_BIT] = condition_flags[CARRY_BIT] & bit_in;
					K_BOR:   next_flags[CARRY_BIT] = condition_flags[CARRY_BIT] | bit_in;
					default: next_flags[CARRY_BIT] = condition_flags[CARRY_BIT] ^ bit_in;
				endcase
			end
			K_LOAD_FLAGS: begin
				update_mask = MASK_FLAGS;
				next_flags  = operand_a[7:0];
			end
			K_AND_FLAGS: begin
				update_mask = MASK_FLAGS;
				next_flags  = condition_flags & operand_a[7:0];
			end
			K_OR_FLAGS: begin
				update_mask = MASK_FLAGS;
				next_flags  = condition_flags | operand_a[7:0];
			end
			K_XOR_FLAGS: begin
				update_mask = MASK_FLAGS;
				next_flags  = condition_flags ^ operand_a[7:0];
			end
			default: update_mask = MASK_NONE;
		endcase
	end

	// ------------------------------------------------------------
	// Flag register
	// ------------------------------------------------------------
	// No reset here: software must load the flags before relying on them.
	genvar gi;
	generate
		for (gi = 0; gi < FLAG_WIDTH; gi++) begin : g_flag
			if (gi > HALF_BIT) begin : g_unused
				assign condition_flags[gi] = 1'b0;
			end else begin : g_used
				always_ff @(posedge mclk) begin
					if (op_valid && update_mask[gi]) begin
						condition_flags[gi] <= next_flags[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			op_result <= 32'h0;
		end else if (op_valid && op_kind != K_CMP) begin
			op_result <= sized;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_half_byte;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_ADD && op_size == SIZE_BYTE)
		|=> condition_flags[HALF_BIT]
			== (({1'b0, $past(operand_a[3:0])} + {1'b0, $past(operand_b[3:0])}) > 5'h0f);
	endproperty
	a_half_byte: assert property (p_half_byte) else $error("byte half-carry wrong");

	property p_half_word_sub;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_SUB && op_size == SIZE_WORD)
		|=> condition_flags[HALF_BIT] == ($past(operand_a[11:0]) < $past(operand_b[11:0]));
	endproperty
	a_half_word_sub: assert property (p_half_word_sub) else $error("word half-borrow wrong");

	property p_half_long;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_ADD && op_size == SIZE_LONG)
		|=> condition_flags[HALF_BIT]
			== (({1'b0, $past(operand_a[27:0])} + {1'b0, $past(operand_b[27:0])}) > 29'h0fffffff);
	endproperty
	a_half_long: assert property (p_half_long) else $error("long half-carry wrong");

	property p_user_kept;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind inside {[K_NOP:K_BXOR]}) |=> $stable(condition_flags[USER_BIT]);
	endproperty
	a_user_kept: assert property (p_user_kept) else $error("user bit changed");

	property p_neg_zero;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_LOGIC && op_size == SIZE_WORD)
		|=> condition_flags[NEG_BIT] == $past(operand_a[15])
			&& condition_flags[ZERO_BIT] == ($past(operand_a[15:0]) == 16'h0)
			&& op_result[15:0] == $past(operand_a[15:0]);
	endproperty
	a_neg_zero: assert property (p_neg_zero) else $error("sign or zero wrong");

	property p_ovf_byte;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_ADD && op_size == SIZE_BYTE
			&& operand_a[7] == operand_b[7])
		|=> condition_flags[OVF_BIT] == (op_result[7] != $past(operand_a[7]));
	endproperty
	a_ovf_byte: assert property (p_ovf_byte) else $error("overflow wrong");

	property p_carry_add;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_ADD && op_size == SIZE_WORD)
		|=> condition_flags[CARRY_BIT]
			== (({1'b0, $past(operand_a[15:0])} + {1'b0, $past(operand_b[15:0])}) > 17'h0ffff);
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("add carry wrong");

	property p_borrow;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_CMP && op_size == SIZE_LONG)
		|=> condition_flags[CARRY_BIT] == ($past(operand_a) < $past(operand_b))
			&& $stable(op_result);
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow wrong");

	property p_shift_carry;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_SHIFT) |=> condition_flags[CARRY_BIT] == $past(shift_out);
	endproperty
	a_shift_carry: assert property (p_shift_carry) else $error("shift carry wrong");

	property p_bit_acc;
		@(posedge mclk) disable iff (rst)
		(op_valid && op_kind == K_BAND)
		|=> condition_flags[CARRY_BIT]
			== ($past(condition_flags[CARRY_BIT]) & ($past(bit_value) ^ $past(bit_invert)))
			&& $stable(condition_flags[HALF_BIT:OVF_BIT]);
	endproperty
	a_bit_acc: assert property (p_bit_acc) else $error("bit accumulator wrong");

	property p_hold;
		@(posedge mclk) disable iff (rst)
		!op_valid |=> $stable(condition_flags);
	endproperty
	a_hold: assert property (p_hold) else $error("flags changed while idle");

endmodule // cpu_condition_flags

// [src/flag_adder.sv]
`timescale 1ns/1ps

module flag_adder
	import cpu_flags_pkg::*;
(
	// Operands
	input  wire logic [31:0] a,
	input  wire logic [31:0] b,
	input  wire logic        carry_in,
	input  wire logic        subtract,
	input  wire size_t       size,
	// Results
	output logic      [31:0] sum,
	output logic             half,
	output logic             carry,
	output logic             ovf
);

	logic [31:0] b_eff;
	logic [32:0] total;
	logic [32:0] carries;

	// Subtraction is a + ~b + ~borrow, so carry out is the inverse of borrow.
	assign b_eff   = subtract ? ~b : b;
	assign total   = {1'b0, a} + {1'b0, b_eff} + {32'h0, subtract ^ carry_in};
	assign carries = {1'b0, a} ^ {1'b0, b_eff} ^ total;
	assign sum     = total[31:0];

	always_comb begin
		unique case (size)
			SIZE_BYTE: begin
				half  = carries[HALF_POS_BYTE + 1] ^ subtract;
				carry = carries[8] ^ subtract;
				ovf   = carries[8] ^ carries[7];
			end
			SIZE_WORD: begin
				half  = carries[HALF_POS_WORD + 1] ^ subtract;
				carry = carries[16] ^ subtract;
				ovf   = carries[16] ^ carries[15];
			end
			default: begin
				half  = carries[HALF_POS_LONG + 1] ^ subtract;
				carry = carries[32] ^ subtract;
				ovf   = carries[32] ^ carries[31];
			end
		endcase
	end

endmodule // flag_adder

// [test/testbench.sv]
`timescale 1ns/1ps

module testbench
	import cpu_flags_pkg::*;
;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        mclk;
	logic        rst;
	logic        op_valid;
	kind_t       op_kind;
	size_t       op_size;
	logic [31:0] operand_a;
	logic [31:0] operand_b;
	logic        shift_out;
	logic        bit_value;
	logic        bit_invert;
	logic [7:0]  condition_flags;
	logic [31:0] op_result;
	int          fails;
	int          n_checks;

	cpu_condition_flags DUT (
		.mclk            (mclk),
		.rst             (rst),
		.op_valid        (op_valid),
		.op_kind         (op_kind),
		.op_size         (op_size),
		.operand_a       (operand_a),
		.operand_b       (operand_b),
		.shift_out       (shift_out),
		.bit_value       (bit_value),
		.bit_invert      (bit_invert),
		.condition_flags (condition_flags),
		.op_result       (op_result)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Closing and checking
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One operation, held for one edge; the flags are compared one cycle later.
	task automatic op(input kind_t k, input size_t s, input logic [31:0] a, input logic [31:0] b,
			input int so, input int bv, input int bi, input logic [7:0] exp);
		@(posedge mclk);
		op_valid   <= 1'b1;
		op_kind    <= k;
		op_size    <= s;
		operand_a  <= a;
		operand_b  <= b;
		shift_out  <= so[0];
		bit_value  <= bv[0];
		bit_invert <= bi[0];
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
		check({24'h000000, condition_flags}, {24'h000000, exp}, k.name());
	endtask

	initial begin
		repeat (1000) @(posedge mclk);
		fails++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		fails      = 0;
		n_checks   = 0;
		rst        = 1'b1;
		op_valid   = 1'b0;
		op_kind    = K_NOP;
		op_size    = SIZE_BYTE;
		operand_a  = 32'h00000000;
		operand_b  = 32'h00000000;
		shift_out  = 1'b0;
		bit_value  = 1'b0;
		bit_invert = 1'b0;
		repeat (4) @(posedge mclk);
		// The first load meets the first edge after release, so no idle edge sees unknown flags.
		rst       <= 1'b0;
		op_valid  <= 1'b1;
		op_kind   <= K_LOAD_FLAGS;
		operand_a <= 32'h000000ff;
		#1;
		check(op_result, 32'h00000000, "result after reset");
		check({30'h00000000, condition_flags[7:6]}, 32'h00000000, "flags 7:6");
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
		check({24'h000000, condition_flags}, 32'h0000003f, "first flag load");
		op(K_LOAD_FLAGS, SIZE_BYTE, 32'h00000010, 32'h0, 0, 0, 0, 8'h10);
		op(K_ADD, SIZE_BYTE, 32'h0000000f, 32'h1, 0, 0, 0, 8'h30);
		check(op_result, 32'h00000010, "byte sum");
		op(K_ADD, SIZE_BYTE, 32'h0000007f, 32'h1, 0, 0, 0, 8'h3a);
		op(K_ADD, SIZE_BYTE, 32'h000000ff, 32'h1, 0, 0, 0, 8'h35);
		op(K_ADDX, SIZE_BYTE, 32'h00000000, 32'h0, 0, 0, 0, 8'h10);
		op(K_SUB, SIZE_BYTE, 32'h00000000, 32'h1, 0, 0, 0, 8'h39);
		op(K_SUBX, SIZE_BYTE, 32'h00000005, 32'h4, 0, 0, 0, 8'h10);
		op(K_CMP, SIZE_BYTE, 32'h00000005, 32'h5, 0, 0, 0, 8'h14);
		op(K_NEG, SIZE_BYTE, 32'h00000000, 32'h1, 0, 0, 0, 8'h39);
		op(K_SUB, SIZE_BYTE, 32'h00000080, 32'h1, 0, 0, 0, 8'h32);
		op(K_ADD, SIZE_WORD, 32'h00000800, 32'h800, 0, 0, 0, 8'h30);
		op(K_ADD, SIZE_WORD, 32'h0000000f, 32'h1, 0, 0, 0, 8'h10);
		op(K_ADD, SIZE_LONG, 32'h08000000, 32'h08000000, 0, 0, 0, 8'h30);
		op(K_ADD, SIZE_LONG, 32'h00000800, 32'h800, 0, 0, 0, 8'h10);
		op(K_ADD, SIZE_WORD, 32'h00007fff, 32'h1, 0, 0, 0, 8'h3a);
		op(K_ADD, SIZE_LONG, 32'hffffffff, 32'h1, 0, 0, 0, 8'h35);
		op(K_SHIFT, SIZE_BYTE, 32'h00000080, 32'h0, 1, 0, 0, 8'h39);
		op(K_LOGIC, SIZE_BYTE, 32'h00000000, 32'h0, 0, 0, 0, 8'h35);
		op(K_NOP, SIZE_BYTE, 32'h00000000, 32'h0, 0, 0, 0, 8'h35);
		op(K_BLOAD, SIZE_BYTE, 32'h00000000, 32'h0, 0, 0, 0, 8'h34);
		op(K_BOR, SIZE_BYTE, 32'h00000000, 32'h0, 0, 0, 1, 8'h35);
		op(K_BAND, SIZE_BYTE, 32'h00000000, 32'h0, 0, 0, 0, 8'h34);
		op(K_BXOR, SIZE_BYTE, 32'h00000000, 32'h0, 0, 1, 0, 8'h35);
		op(K_AND_FLAGS, SIZE_BYTE, 32'h0000000f, 32'h0, 0, 0, 0, 8'h05);
		op(K_OR_FLAGS, SIZE_BYTE, 32'h00000010, 32'h0, 0, 0, 0, 8'h15);
		op(K_XOR_FLAGS, SIZE_BYTE, 32'h00000030, 32'h0, 0, 0, 0, 8'h25);
		op(K_SUB, SIZE_WORD, 32'h00001000, 32'h1, 0, 0, 0, 8'h20);
		check(op_result, 32'h00000fff, "word difference");
		op(K_LOGIC, SIZE_WORD, 32'h12348000, 32'h0, 0, 0, 0, 8'h28);
		check(op_result, 32'h00008000, "word result zero-extended");
		op(K_CMP, SIZE_LONG, 32'h00000001, 32'h2, 0, 0, 0, 8'h29);
		check(op_result, 32'h00008000, "result kept by compare");
		// A reset in mid-run clears the result but leaves the flags alone.
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check(op_result, 32'h00000000, "result after second reset");
		check({24'h000000, condition_flags}, 32'h00000029, "flags kept over reset");
		op(K_ADD, SIZE_BYTE, 32'h00000001, 32'h1, 0, 0, 0, 8'h00);
		check(op_result, 32'h00000002, "sum after second reset");
		end_of_test();
	end

endmodule // testbench
